// >>> design/dts_channel.sv
// one timer channel: compare match, wrap detection and output pin action
`timescale 1ns/100ps
`default_nettype none
module dts_channel (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] counter,
  input wire logic [7:0] constant_a,
  input wire logic [7:0] constant_b,
  input wire logic [1:0] action_a,
  input wire logic [1:0] action_b,
  output logic match_a_evt,
  output logic match_b_evt,
  output logic wrap_evt,
  output logic pin
);

  typedef struct packed {
    logic [7:0] prev_cnt;
    logic eq_a;
    logic eq_b;
    logic pin;
  } dts_chan_s;

  dts_chan_s st_r;
  dts_chan_s st_nxt;
  logic eq_a;
  logic eq_b;

  function automatic logic apply_action(input logic cur,
                                        input logic [1:0] act);
    case (dts_pkg::dts_action_e'(act))
      dts_pkg::DTS_ACT_KEEP: apply_action = cur;
      dts_pkg::DTS_ACT_LOW: apply_action = 1'b0;
      dts_pkg::DTS_ACT_HIGH: apply_action = 1'b1;
      dts_pkg::DTS_ACT_TOGGLE: apply_action = ~cur;
      default: apply_action = cur;
    endcase
  endfunction : apply_action

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  // a counter may dwell on one value for many clocks under a prescaler,
  // so only the first cycle of equality counts as a match
  assign eq_a = (counter == constant_a);
  assign eq_b = (counter == constant_b);
  assign match_a_evt = eq_a & ~st_r.eq_a;
  assign match_b_evt = eq_b & ~st_r.eq_b;
  assign wrap_evt = (st_r.prev_cnt == dts_pkg::CNT_MAX) &&
                    (counter == dts_pkg::CNT_ZERO);
  assign pin = st_r.pin;

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev_cnt = counter;
    st_nxt.eq_a = eq_a;
    st_nxt.eq_b = eq_b;
    // b is applied to the pin value that a produced when both match together
    if (match_a_evt) begin
      st_nxt.pin = apply_action(st_r.pin, action_a);
    end
    if (match_b_evt) begin
      st_nxt.pin = apply_action(match_a_evt ? st_nxt.pin : st_r.pin,
                                action_b);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : dts_channel
`default_nettype wire

// >>> design/dts_pkg.sv
// constants shared by the dual timer status and output control block
package dts_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the avalon slave
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_X_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_Y_STATUS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hc;

  // ----------------------------------------------------------------
  // status/control field positions
  // ----------------------------------------------------------------
  localparam int BIT_MATCH_B_FLAG = 7;
  localparam int BIT_MATCH_A_FLAG = 6;
  localparam int BIT_WRAP_FLAG = 5;
  localparam int BIT_CAPTURE_DONE_FLAG = 4;
  localparam int BIT_CAPTURE_IRQ_ENABLE = 4;
  localparam int BIT_MATCH_B_ACTION_HI = 3;
  localparam int BIT_MATCH_B_ACTION_LO = 2;
  localparam int BIT_MATCH_A_ACTION_HI = 1;
  localparam int BIT_MATCH_A_ACTION_LO = 0;

  // ----------------------------------------------------------------
  // interrupt status and mask bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_W = 7;
  localparam int IRQ_X_MATCH_B = 0;
  localparam int IRQ_X_MATCH_A = 1;
  localparam int IRQ_X_WRAP = 2;
  localparam int IRQ_X_CAPTURE = 3;
  localparam int IRQ_Y_MATCH_B = 4;
  localparam int IRQ_Y_MATCH_A = 5;
  localparam int IRQ_Y_WRAP = 6;

  // ----------------------------------------------------------------
  // counter width, wrap values, reset values
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] IRQ_RESET = 7'h00;

  // ----------------------------------------------------------------
  // output actions on compare match
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTS_ACT_KEEP = 2'b00,
    DTS_ACT_LOW = 2'b01,
    DTS_ACT_HIGH = 2'b10,
    DTS_ACT_TOGGLE = 2'b11
  } dts_action_e;

  // capture edge tracker on the external reset input
  typedef enum logic [0:0] {
    DTS_CAP_WAIT_RISE = 1'b0,
    DTS_CAP_WAIT_FALL = 1'b1
  } dts_cap_e;

endpackage : dts_pkg

// >>> design/dts_top.sv
// dual timer status flags, output control and avalon register slave
// Contract
// - x match b flag, bit 7, sets when x counter equals constant b
// - x match a flag, bit 6, sets when x counter equals constant a
// - x wrap flag, bit 5, sets when x counter goes ff to 00
// - x capture flag, bit 4, sets after rise then fall on reset input
// - flags clear by writing zero after reading one; reset to zero
// - y match b flag, bit 7, sets when y counter equals constant b
// - y match a flag, bit 6, sets when y counter equals constant a
// - y wrap flag, bit 5, sets when y counter goes ff to 00
// - y bit 4 enables capture interrupt request from x capture flag
// - x bits 3:2 pick x pin action at match b
// - x bits 1:0 pick x pin action at match a
// - y bits 3:2 pick y pin action at match b
// - y bits 1:0 pick y pin action at match a
// - external reset input edges rise then fall mark one capture
`timescale 1ns/100ps
`default_nettype none
module dts_top (
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // timer side
  input wire logic [7:0] channel_x_counter,
  input wire logic [7:0] channel_x_constant_a,
  input wire logic [7:0] channel_x_constant_b,
  input wire logic [7:0] channel_y_counter,
  input wire logic [7:0] channel_y_constant_a,
  input wire logic [7:0] channel_y_constant_b,
  input wire logic external_reset_input,
  output logic channel_x_output_pin,
  output logic channel_y_output_pin,
  output logic capture_irq_request,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] x_flags;
    logic [3:0] x_sel;
    logic [2:0] y_flags;
    logic y_irq_en;
    logic [3:0] y_sel;
    logic [3:0] x_arm;
    logic [2:0] y_arm;
    dts_pkg::dts_cap_e cap;
    logic ext_prev;
    logic [6:0] irq_stat;
    logic [6:0] irq_mask;
    logic waitrequest;
    logic [31:0] readdata;
    logic irq;
    logic cap_irq;
    logic pin_x;
    logic pin_y;
  } dts_top_s;

  dts_top_s st_r;
  dts_top_s st_nxt;

  logic x_match_a;
  logic x_match_b;
  logic x_wrap;
  logic y_match_a;
  logic y_match_b;
  logic y_wrap;
  logic x_pin_int;
  logic y_pin_int;
  logic cap_evt;
  logic req;
  logic done;
  logic wr_lane;
  logic [7:0] wbyte;
  logic [3:0] x_evt;
  logic [2:0] y_evt;
  logic [6:0] irq_evt;
  logic [3:0] x_clr;
  logic [2:0] y_clr;
  logic [7:0] x_reg;
  logic [7:0] y_reg;

  // set wins over clear for every sticky bit
  function automatic logic [3:0] flag_upd(input logic [3:0] cur,
                                          input logic [3:0] set,
                                          input logic [3:0] clr);
    flag_upd = set | (cur & ~clr);
  endfunction : flag_upd

  function automatic logic is_at(input logic [3:0] addr,
                                 input logic [3:0] ofs);
    is_at = (addr == ofs);
  endfunction : is_at

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  dts_channel u_chan_x (
    .clk(clk),
    .reset_n(reset_n),
    .counter(channel_x_counter),
    .constant_a(channel_x_constant_a),
    .constant_b(channel_x_constant_b),
    .action_a(st_r.x_sel[dts_pkg::BIT_MATCH_A_ACTION_HI:
                         dts_pkg::BIT_MATCH_A_ACTION_LO]),
    .action_b(st_r.x_sel[dts_pkg::BIT_MATCH_B_ACTION_HI:
                         dts_pkg::BIT_MATCH_B_ACTION_LO]),
    .match_a_evt(x_match_a),
    .match_b_evt(x_match_b),
    .wrap_evt(x_wrap),
    .pin(x_pin_int)
  );

  dts_channel u_chan_y (
    .clk(clk),
    .reset_n(reset_n),
    .counter(channel_y_counter),
    .constant_a(channel_y_constant_a),
    .constant_b(channel_y_constant_b),
    .action_a(st_r.y_sel[dts_pkg::BIT_MATCH_A_ACTION_HI:
                         dts_pkg::BIT_MATCH_A_ACTION_LO]),
    .action_b(st_r.y_sel[dts_pkg::BIT_MATCH_B_ACTION_HI:
                         dts_pkg::BIT_MATCH_B_ACTION_LO]),
    .match_a_evt(y_match_a),
    .match_b_evt(y_match_b),
    .wrap_evt(y_wrap),
    .pin(y_pin_int)
  );

  // ----------------------------------------------------------------
  // capture edge pair
  // ----------------------------------------------------------------
  // a fall seen before any rise is ignored; only rise then fall counts
  assign cap_evt = (st_r.cap == dts_pkg::DTS_CAP_WAIT_FALL) &&
                   st_r.ext_prev && !external_reset_input;

  // ----------------------------------------------------------------
  // event vectors, in status register bit order 7..4 for x and 7..5 for y, and interrupt status bit order 6..0
  // ----------------------------------------------------------------
  assign x_evt = {x_match_b, x_match_a, x_wrap, cap_evt};
  assign y_evt = {y_match_b, y_match_a, y_wrap};
  assign irq_evt = {y_wrap, y_match_a, y_match_b,
                    cap_evt, x_wrap, x_match_a, x_match_b};

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one wait cycle: the request is seen with waitrequest high, the
  // answer edge follows one clock later
  assign req = read | write;
  assign done = req & ~st_r.waitrequest;
  assign wr_lane = write & done & byteenable[0];
  assign wbyte = writedata[7:0];

  assign x_reg = {st_r.x_flags, st_r.x_sel};
  assign y_reg = {st_r.y_flags, st_r.y_irq_en, st_r.y_sel};

  // clearing needs a prior read of one, tracked by the arm bits
  always_comb begin
    x_clr = '0;
    y_clr = '0;
    if (wr_lane && is_at(address, dts_pkg::OFS_X_STATUS_CONTROL)) begin
      x_clr = st_r.x_arm & ~wbyte[7:4];
    end
    if (wr_lane && is_at(address, dts_pkg::OFS_Y_STATUS_CONTROL)) begin
      y_clr = st_r.y_arm & ~wbyte[7:5];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // capture tracker
    st_nxt.ext_prev = external_reset_input;
    case (st_r.cap)
      dts_pkg::DTS_CAP_WAIT_RISE: begin
        if (!st_r.ext_prev && external_reset_input) begin
          st_nxt.cap = dts_pkg::DTS_CAP_WAIT_FALL;
        end
      end
      dts_pkg::DTS_CAP_WAIT_FALL: begin
        if (cap_evt) begin
          st_nxt.cap = dts_pkg::DTS_CAP_WAIT_RISE;
        end
      end
      default: begin
        st_nxt.cap = dts_pkg::DTS_CAP_WAIT_RISE;
      end
    endcase

    // event flags
    st_nxt.x_flags = flag_upd(st_r.x_flags, x_evt, x_clr);
    st_nxt.y_flags = 3'(flag_upd({1'b0, st_r.y_flags}, {1'b0, y_evt},
                                 {1'b0, y_clr}));

    // bus handshake
    st_nxt.waitrequest = ~(req & st_r.waitrequest);

    if (req && st_r.waitrequest) begin
      st_nxt.readdata = '0;
      if (read) begin
        if (is_at(address, dts_pkg::OFS_X_STATUS_CONTROL)) begin
          st_nxt.readdata = {24'h000000, x_reg};
        end else if (is_at(address, dts_pkg::OFS_Y_STATUS_CONTROL)) begin
          st_nxt.readdata = {24'h000000, y_reg};
        end else if (is_at(address, dts_pkg::OFS_IRQ_STATUS)) begin
          st_nxt.readdata = {25'h0000000, st_r.irq_stat};
        end else if (is_at(address, dts_pkg::OFS_IRQ_MASK)) begin
          st_nxt.readdata = {25'h0000000, st_r.irq_mask};
        end
      end
    end

    // arming: only flags the completed read returned as one; a flag set
    // during the wait cycle was never seen by software, so it stays unarmed
    if (done && read) begin
      if (is_at(address, dts_pkg::OFS_X_STATUS_CONTROL)) begin
        st_nxt.x_arm = st_r.readdata[7:4];
      end
      if (is_at(address, dts_pkg::OFS_Y_STATUS_CONTROL)) begin
        st_nxt.y_arm = st_r.readdata[7:5];
      end
    end

    // writes take effect at the completing edge
    if (done && write) begin
      if (is_at(address, dts_pkg::OFS_X_STATUS_CONTROL)) begin
        st_nxt.x_arm = '0;
        if (byteenable[0]) begin
          st_nxt.x_sel = wbyte[3:0];
        end
      end
      if (is_at(address, dts_pkg::OFS_Y_STATUS_CONTROL)) begin
        st_nxt.y_arm = '0;
        if (byteenable[0]) begin
          st_nxt.y_irq_en = wbyte[dts_pkg::BIT_CAPTURE_IRQ_ENABLE];
          st_nxt.y_sel = wbyte[3:0];
        end
      end
      if (byteenable[0] && is_at(address, dts_pkg::OFS_IRQ_MASK)) begin
        st_nxt.irq_mask = wbyte[6:0];
      end
    end

    // interrupt status: write one to clear, a new event wins
    if (wr_lane && is_at(address, dts_pkg::OFS_IRQ_STATUS)) begin
      st_nxt.irq_stat = irq_evt | (st_r.irq_stat & ~wbyte[6:0]);
    end else begin
      st_nxt.irq_stat = irq_evt | st_r.irq_stat;
    end

    // irq and capture request follow the next state, so they lag nothing; the pins lag the channel pin by one clock
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    st_nxt.cap_irq = st_nxt.x_flags[dts_pkg::BIT_CAPTURE_DONE_FLAG - 4] &
                     st_nxt.y_irq_en;
    st_nxt.pin_x = x_pin_int;
    st_nxt.pin_y = y_pin_int;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.waitrequest <= 1'b1;
      st_r.cap <= dts_pkg::DTS_CAP_WAIT_RISE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readdata = st_r.readdata;
  assign waitrequest = st_r.waitrequest;
  assign channel_x_output_pin = st_r.pin_x;
  assign channel_y_output_pin = st_r.pin_y;
  assign capture_irq_request = st_r.cap_irq;
  assign irq = st_r.irq;

endmodule : dts_top
`default_nettype wire

// >>> dv/dts_assertions.sv
// port checker for the dual timer status block
`timescale 1ns/100ps
`default_nettype none
module dts_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [7:0] channel_x_counter,
  input wire logic [7:0] channel_x_constant_a,
  input wire logic [7:0] channel_x_constant_b,
  input wire logic [7:0] channel_y_counter,
  input wire logic [7:0] channel_y_constant_a,
  input wire logic [7:0] channel_y_constant_b,
  input wire logic external_reset_input,
  input wire logic channel_x_output_pin,
  input wire logic channel_y_output_pin,
  input wire logic capture_irq_request,
  input wire logic irq
);
  // ------------------------------------------------------------
  // helpers: match entries and ages of recent causes
  // ------------------------------------------------------------
  logic [3:0] eq;
  logic [3:0] eq_r;
  logic [7:0] cx_r;
  logic [7:0] cy_r;
  logic ext_r;
  logic hx_r;
  logic hy_r;
  logic done;
  logic fall;
  logic cause;
  logic [2:0] wr_age;
  logic [2:0] cap_age;
  logic [2:0] any_age;
  assign eq = {channel_x_counter == channel_x_constant_a,
    channel_x_counter == channel_x_constant_b,
    channel_y_counter == channel_y_constant_a,
    channel_y_counter == channel_y_constant_b};
  assign done = write && !waitrequest;
  assign fall = ext_r && !external_reset_input;
  assign cause = (|(eq & ~eq_r)) || done || fall
    || (cx_r == 8'hff && channel_x_counter == 8'h00)
    || (cy_r == 8'hff && channel_y_counter == 8'h00);
  // ages saturate so a long quiet spell never wraps to look recent
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eq_r <= 4'h0;
      cx_r <= 8'h00;
      cy_r <= 8'h00;
      ext_r <= 1'b0;
      hx_r <= 1'b0;
      hy_r <= 1'b0;
      wr_age <= 3'h7;
      cap_age <= 3'h7;
      any_age <= 3'h7;
    end else begin
      eq_r <= eq;
      cx_r <= channel_x_counter;
      cy_r <= channel_y_counter;
      ext_r <= external_reset_input;
      hx_r <= |(eq[3:2] & ~eq_r[3:2]);
      hy_r <= |(eq[1:0] & ~eq_r[1:0]);
      wr_age <= done ? 3'h0 : wr_age + {2'h0, wr_age != 3'h7};
      cap_age <= (done || fall) ? 3'h0 : cap_age + {2'h0, cap_age != 3'h7};
      any_age <= cause ? 3'h0 : any_age + {2'h0, any_age != 3'h7};
    end
  end
  a_wait_answer: assert property (@(posedge clk) disable iff (!reset_n)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (@(posedge clk) disable iff (!reset_n)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n)
    read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0)
    else $error("unmapped read returned nonzero");
  a_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
    read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_xpin_cause: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(channel_x_output_pin) |-> hx_r || $past(hx_r))
    else $error("x pin moved without a match");
  a_ypin_cause: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(channel_y_output_pin) |-> hy_r || $past(hy_r))
    else $error("y pin moved without a match");
  a_capreq_cause: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(capture_irq_request) |-> cap_age <= 3'h4)
    else $error("capture request rose without capture or write");
  a_irq_cause: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(irq) |-> any_age <= 3'h4)
    else $error("irq rose without an event or write");
  a_irq_clear: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(irq) || $fell(capture_irq_request) |-> wr_age <= 3'h4)
    else $error("interrupt fell without a write");
endmodule : dts_assertions
bind dts_top dts_assertions u_chk (.clk, .reset_n, .address, .read, .write,
  .readdata, .waitrequest, .channel_x_counter, .channel_x_constant_a,
  .channel_x_constant_b, .channel_y_counter, .channel_y_constant_a,
  .channel_y_constant_b, .external_reset_input, .channel_x_output_pin,
  .channel_y_output_pin, .capture_irq_request, .irq);
`default_nettype wire

// >>> dv/dts_timer_model.sv
// timer side model: counters, constants and external reset input
`timescale 1ns/100ps
`default_nettype none
module dts_timer_model (
  input wire logic clk,
  output logic [7:0] channel_x_counter,
  output logic [7:0] channel_x_constant_a,
  output logic [7:0] channel_x_constant_b,
  output logic [7:0] channel_y_counter,
  output logic [7:0] channel_y_constant_a,
  output logic [7:0] channel_y_constant_b,
  output logic external_reset_input
);
  // ------------------------------------------------------------
  // drivers, changed only just after a rising edge
  // ------------------------------------------------------------
  // counters start off the constants so reset sees no match
  initial begin
    channel_x_counter = 8'h01;
    channel_y_counter = 8'h01;
    channel_x_constant_a = 8'h10;
    channel_x_constant_b = 8'h20;
    channel_y_constant_a = 8'h10;
    channel_y_constant_b = 8'h20;
    external_reset_input = 1'b0;
  end
  task automatic put(input logic ch, input logic [7:0] v);
    @(posedge clk);
    if (ch) channel_y_counter <= v;
    else channel_x_counter <= v;
  endtask : put
  task automatic edge_in(input logic v);
    @(posedge clk);
    external_reset_input <= v;
  endtask : edge_in
endmodule : dts_timer_model
`default_nettype wire

// >>> dv/tb_dual_timer_status_output_ctrl.sv
// self-checking bench for the dual timer status block
`timescale 1ns/100ps
`default_nettype none
module tb_dual_timer_status_output_ctrl;
  // ------------------------------------------------------------
  // clock, reset, bus, model and design
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [7:0] channel_x_counter, channel_x_constant_a, channel_x_constant_b;
  logic [7:0] channel_y_counter, channel_y_constant_a, channel_y_constant_b;
  logic external_reset_input;
  logic channel_x_output_pin, channel_y_output_pin;
  logic capture_irq_request, irq;
  int miscompares = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  dts_timer_model tm (.clk, .channel_x_counter, .channel_x_constant_a,
    .channel_x_constant_b, .channel_y_counter, .channel_y_constant_a,
    .channel_y_constant_b, .external_reset_input);
  dts_top dut (.clk, .reset_n, .address, .read, .write,
    .byteenable(4'h1), .writedata, .readdata, .waitrequest,
    .channel_x_counter, .channel_x_constant_a, .channel_x_constant_b,
    .channel_y_counter, .channel_y_constant_a, .channel_y_constant_b,
    .external_reset_input, .channel_x_output_pin, .channel_y_output_pin,
    .capture_irq_request, .irq);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, d};
    // no local limit: the watchdog ends a wait that never finishes
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, exp});
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic close_out;
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h00);
    rd(4'hc, 8'h00);
  endtask : t_reset
  task automatic t_flags(input logic ch);
    logic [3:0] b;
    b = ch ? 4'h4 : 4'h0;
    tm.put(ch, 8'h10);
    tm.put(ch, 8'h20);
    tm.put(ch, 8'hff);
    tm.put(ch, 8'h00);
    settle(3);
    rd(b, 8'he0);
    rd(4'h8, ch ? 8'h70 : 8'h07);
    wr(4'h8, 8'h7f);
    rd(4'h8, 8'h00);
    wr(b, 8'h00);
    rd(b, 8'h00);
    tm.put(ch, 8'h10);
    settle(3);
    // a clear with no fresh read of the flag must be refused
    wr(b, 8'h00);
    rd(b, 8'h40);
    wr(b, 8'h00);
    rd(b, 8'h00);
    // a clearing write and a fresh match land on one edge: set wins
    tm.put(ch, 8'h55);
    tm.put(ch, 8'h10);
    tm.put(ch, 8'h55);
    settle(2);
    rd(b, 8'h40);
    fork
      wr(b, 8'h00);
      begin
        @(posedge clk);
        tm.put(ch, 8'h10);
      end
    join
    settle(2);
    rd(b, 8'h40);
    wr(b, 8'h00);
    rd(b, 8'h00);
    // leave equality so the next scenario sees a fresh match entry
    tm.put(ch, 8'h55);
    wr(4'h8, 8'h7f);
  endtask : t_flags
  task automatic t_pins(input logic ch);
    logic [1:0] codes [5];
    logic [1:0] c;
    logic exp;
    codes = '{2'b10, 2'b01, 2'b11, 2'b00, 2'b11};
    exp = 1'b0;
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 5; i++) begin
        c = codes[i];
        wr(ch ? 4'h4 : 4'h0, j ? {4'h0, c, 2'h0} : {6'h0, c});
        tm.put(ch, j ? 8'h20 : 8'h10);
        tm.put(ch, 8'h55);
        settle(4);
        exp = c == 2'b11 ? !exp : c == 2'b10 ? 1'b1 : c == 2'b01 ? 1'b0 : exp;
        chk({31'h0, ch ? channel_y_output_pin : channel_x_output_pin}, {31'h0, exp});
      end
    end
    rd(ch ? 4'h4 : 4'h0, 8'hcc);
    wr(ch ? 4'h4 : 4'h0, 8'h00);
  endtask : t_pins
  task automatic t_capture;
    tm.edge_in(1'b1);
    settle(3);
    rd(4'h0, 8'h00);
    tm.edge_in(1'b0);
    settle(3);
    rd(4'h0, 8'h10);
    chk({31'h0, capture_irq_request}, 32'h0);
    wr(4'h4, 8'h10);
    settle(3);
    chk({31'h0, capture_irq_request}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(4'hc, 8'h08);
    settle(3);
    chk({31'h0, irq}, 32'h1);
    wr(4'h8, 8'h08);
    settle(3);
    chk({31'h0, irq}, 32'h0);
    rd(4'h0, 8'h10);
    wr(4'h0, 8'h00);
    settle(3);
    chk({31'h0, capture_irq_request}, 32'h0);
    rd(4'h4, 8'h10);
  endtask : t_capture
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_flags(1'b0);
    t_flags(1'b1);
    t_pins(1'b0);
    t_pins(1'b1);
    t_capture();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule : tb_dual_timer_status_output_ctrl
`default_nettype wire
